/* File: rtl/touch_readback_pkg.sv */
// Purpose: constants and types shared by the touch result readback block
// Assumes: register indices are word indices; byte address is four times the index
// Notes:   all timing of this block is in whole clock cycles, no long counts
package touch_readback_pkg;

  // ***************************************************************
  // register indices (byte address = index * 4)
  // ***************************************************************
  localparam logic [15:0] IDX_STATUS = 16'h4011;
  localparam logic [15:0] IDX_MASK   = 16'h4019;
  localparam logic [15:0] IDX_HORIZ  = 16'h402a;
  localparam logic [15:0] IDX_VERT   = 16'h402b;
  localparam logic [15:0] IDX_PRESS  = 16'h402c;
  localparam logic [15:0] IDX_CTRL   = 16'h4030;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int RES_W  = 12;

  // ***************************************************************
  // field positions and reset values
  // ***************************************************************
  localparam int BIT_READY        = 10;
  localparam int BIT_CONTACT      = 9;
  localparam int BIT_CONTACT_FLAG = 15;
  localparam int BIT_HORIZ_EN     = 8;
  localparam int BIT_VERT_EN      = 9;
  localparam int BIT_PRESS_EN     = 10;
  localparam int BIT_FOUR_WIRE    = 0;

  localparam logic [REG_W-1:0] STATUS_USED = 16'h0600;
  localparam logic [REG_W-1:0] MASK_RST    = 16'h0600;
  localparam logic [REG_W-1:0] CTRL_USED   = 16'h0701;
  localparam logic [REG_W-1:0] CTRL_RST    = 16'h0001;
  localparam logic [REG_W-1:0] RESULT_RST  = 16'h0000;

  // axis codes double as switch matrix selects
  localparam logic [1:0] AX_HORIZ = 2'h0;
  localparam logic [1:0] AX_VERT  = 2'h1;
  localparam logic [1:0] AX_PRESS = 2'h2;
  localparam logic [1:0] AX_NONE  = 2'h3;

  typedef enum logic {SEQ_IDLE, SEQ_CONV} seq_state_t;

endpackage : touch_readback_pkg

/* File: rtl/touch_panel_readback_irq.sv */
// Purpose: touch result registers, measurement hold-off, event flags and interrupts
// Assumes: APB3 slave with no wait states; adc engine answers adcStart with adcDone
// Notes:   pen comparator is asynchronous and passes a three-stage synchroniser
//
// Contract
// RULE1: horizontal, vertical, pressure results kept as 12-bit low fields, reset zero
// RULE2: bit 15 of each result shows pen contact seen before that measurement
// RULE3: reading any result register starts hold-off blocking new measurement starts
// RULE4: hold-off ends once every enabled channel's result register was read
// RULE5: any access to a non-result register ends hold-off at once
// RULE6: all three enabled need three reads; fewer enabled need fewer reads
// RULE7: pressure measured only in four-wire mode, never in five-wire mode
// RULE8: data-ready flag, status bit 10, set on each new complete result set
// RULE9: pen-down flag, status bit 9, set on rising edge of pen contact
// RULE10: writing one clears an event flag, writing zero leaves it
// RULE11: each flag drives its own interrupt output unless masked
// RULE12: mask bits 10 and 9 block when one, pass when zero, reset one
// RULE13: comparator high means panel touched, low means not touched
// RULE14: each axis configured and converted separately, one after another
// RULE15: per-channel enable bits choose which results must be read
// RULE16: reset clears hold-off and the record of reads
`timescale 1ns/100ps
module touch_panel_readback_irq #(
  parameter int RES_W = touch_readback_pkg::RES_W
) (
  input  wire logic                                clk,
  input  wire logic                                srst,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [touch_readback_pkg::ADDR_W-1:0] paddr,
  input  wire logic [touch_readback_pkg::DATA_W-1:0] pwdata,
  output logic      [touch_readback_pkg::DATA_W-1:0] prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic                                penComparator,
  input  wire logic                                measStart,
  output logic                                     adcStart,
  output logic      [1:0]                          matrixSel,
  input  wire logic                                adcDone,
  input  wire logic [RES_W-1:0]                    adcData,
  output logic                                     measHoldoff,
  output logic                                     measBusy,
  output logic                                     resultReadyIrq,
  output logic                                     contactIrq,
  output logic                                     irq
);

  if (RES_W != touch_readback_pkg::RES_W) begin : g_res_chk
    $error("result width must match the register field width");
  end

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [1:0] next_axis(input logic [1:0] cur, input logic [2:0] req);
    logic [1:0] r;
    r = touch_readback_pkg::AX_NONE;
    if (cur == touch_readback_pkg::AX_NONE && req[0]) begin
      r = touch_readback_pkg::AX_HORIZ;
    end else if ((cur == touch_readback_pkg::AX_NONE || cur == touch_readback_pkg::AX_HORIZ)
                 && req[1]) begin
      r = touch_readback_pkg::AX_VERT;
    end else if (cur != touch_readback_pkg::AX_PRESS && req[2]) begin
      r = touch_readback_pkg::AX_PRESS;
    end
    return r;
  endfunction : next_axis

  function automatic logic [touch_readback_pkg::DATA_W-1:0] widen(
    input logic [touch_readback_pkg::REG_W-1:0] v);
    return {{(touch_readback_pkg::DATA_W - touch_readback_pkg::REG_W){1'b0}}, v};
  endfunction : widen

  // ***************************************************************
  // pen comparator synchroniser
  // ***************************************************************
  logic [2:0] penSync_ff;
  logic [2:0] nxt_penSync;
  logic       penState_ff;
  logic       nxt_penState;
  logic       contactRise;

  always_comb begin
    nxt_penSync  = {penSync_ff[1:0], penComparator};
    nxt_penState = penState_ff;
    // glitch guard: a change counts only once stages two and three agree
    if (penSync_ff[1] == penSync_ff[2]) begin
      nxt_penState = penSync_ff[2]; // RULE13
    end
    if (srst) begin
      nxt_penSync  = 3'h0;
      nxt_penState = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    penSync_ff  <= nxt_penSync;
    penState_ff <= nxt_penState;
  end

  assign contactRise = nxt_penState & ~penState_ff; // RULE9

  // ***************************************************************
  // apb decode and registers
  // ***************************************************************
  logic [15:0]                         regIdx;
  logic                                accessEn;
  logic                                hitStatus, hitMask, hitCtrl;
  logic                                hitHoriz, hitVert, hitPress, hitResult, mapped;
  logic [touch_readback_pkg::REG_W-1:0] status_ff, nxt_status;
  logic [touch_readback_pkg::REG_W-1:0] mask_ff, nxt_mask;
  logic [touch_readback_pkg::REG_W-1:0] ctrl_ff, nxt_ctrl;
  logic [touch_readback_pkg::DATA_W-1:0] prdata_ff, nxt_prdata;
  logic                                holdoff_ff, nxt_holdoff;
  logic [2:0]                          readSeen_ff, nxt_readSeen;
  logic [2:0]                          reqMask;
  logic                                fourWire;
  logic                                setDone_ff;
  logic [touch_readback_pkg::REG_W-1:0] horiz_ff, vert_ff, press_ff;

  assign regIdx    = paddr[touch_readback_pkg::ADDR_W-1:2];
  assign accessEn  = psel & penable;
  assign hitStatus = regIdx == touch_readback_pkg::IDX_STATUS;
  assign hitMask   = regIdx == touch_readback_pkg::IDX_MASK;
  assign hitCtrl   = regIdx == touch_readback_pkg::IDX_CTRL;
  assign hitHoriz  = regIdx == touch_readback_pkg::IDX_HORIZ;
  assign hitVert   = regIdx == touch_readback_pkg::IDX_VERT;
  assign hitPress  = regIdx == touch_readback_pkg::IDX_PRESS;
  assign hitResult = hitHoriz | hitVert | hitPress;
  assign mapped    = hitResult | hitStatus | hitMask | hitCtrl;
  assign fourWire  = ctrl_ff[touch_readback_pkg::BIT_FOUR_WIRE];
  assign reqMask   = {ctrl_ff[touch_readback_pkg::BIT_PRESS_EN] & fourWire, // RULE7
                      ctrl_ff[touch_readback_pkg::BIT_VERT_EN],
                      ctrl_ff[touch_readback_pkg::BIT_HORIZ_EN]};             // RULE15

  always_comb begin
    nxt_status   = status_ff;
    nxt_mask     = mask_ff;
    nxt_ctrl     = ctrl_ff;
    nxt_prdata   = prdata_ff;
    nxt_holdoff  = holdoff_ff;
    nxt_readSeen = readSeen_ff;
    // read data captured in the setup phase so it comes from a flop
    if (psel && !penable) begin
      nxt_prdata = '0;
      if (hitStatus) nxt_prdata = widen(status_ff);
      if (hitMask)   nxt_prdata = widen(mask_ff);
      if (hitCtrl)   nxt_prdata = widen(ctrl_ff);
      if (hitHoriz)  nxt_prdata = widen(horiz_ff);
      if (hitVert)   nxt_prdata = widen(vert_ff);
      if (hitPress)  nxt_prdata = widen(press_ff);
    end
    if (accessEn && pwrite) begin
      if (hitStatus) begin
        nxt_status = status_ff & ~(pwdata[touch_readback_pkg::REG_W-1:0] &
                                   touch_readback_pkg::STATUS_USED); // RULE10
      end
      if (hitMask) begin
        nxt_mask = pwdata[touch_readback_pkg::REG_W-1:0] & touch_readback_pkg::STATUS_USED;
      end
      if (hitCtrl) begin
        nxt_ctrl = pwdata[touch_readback_pkg::REG_W-1:0] & touch_readback_pkg::CTRL_USED;
      end
    end
    // a new event in the clearing cycle wins over the clear
    if (setDone_ff) nxt_status[touch_readback_pkg::BIT_READY] = 1'b1;     // RULE8
    if (contactRise) nxt_status[touch_readback_pkg::BIT_CONTACT] = 1'b1;  // RULE9
    if (accessEn && !pwrite && hitResult) begin
      nxt_holdoff  = 1'b1;                                      // RULE3
      nxt_readSeen = readSeen_ff | {hitPress, hitVert, hitHoriz};
    end
    // unmapped addresses count as another register too
    if (accessEn && !hitResult) begin
      nxt_holdoff  = 1'b0;                                      // RULE5
      nxt_readSeen = 3'h0;
    end
    if (nxt_holdoff && ((nxt_readSeen & reqMask) == reqMask)) begin
      nxt_holdoff  = 1'b0;                                      // RULE4 RULE6
      nxt_readSeen = 3'h0;
    end
    if (srst) begin
      nxt_status   = '0;
      nxt_mask     = touch_readback_pkg::MASK_RST;              // RULE12
      nxt_ctrl     = touch_readback_pkg::CTRL_RST;
      nxt_prdata   = '0;
      nxt_holdoff  = 1'b0;                                      // RULE16
      nxt_readSeen = 3'h0;
    end
  end

  always_ff @(posedge clk) begin
    status_ff   <= nxt_status;
    mask_ff     <= nxt_mask;
    ctrl_ff     <= nxt_ctrl;
    prdata_ff   <= nxt_prdata;
    holdoff_ff  <= nxt_holdoff;
    readSeen_ff <= nxt_readSeen;
  end

  assign prdata  = prdata_ff;
  assign pready  = 1'b1;
  assign pslverr = accessEn & ~mapped;

  assign resultReadyIrq = status_ff[touch_readback_pkg::BIT_READY] &
                          ~mask_ff[touch_readback_pkg::BIT_READY];      // RULE11 RULE12
  assign contactIrq     = status_ff[touch_readback_pkg::BIT_CONTACT] &
                          ~mask_ff[touch_readback_pkg::BIT_CONTACT];    // RULE11 RULE12
  assign irq            = resultReadyIrq | contactIrq;
  assign measHoldoff    = holdoff_ff;

  // ***************************************************************
  // measurement sequencer
  // ***************************************************************
  touch_readback_pkg::seq_state_t state_ff, nxt_state;
  logic [1:0]                          axis_ff, nxt_axis, firstAxis, followAxis;
  logic                                adcStart_ff, nxt_adcStart;
  logic                                penAtStart_ff, nxt_penAtStart;
  logic                                nxt_setDone;
  logic [touch_readback_pkg::REG_W-1:0] nxt_horiz, nxt_vert, nxt_press;
  logic [touch_readback_pkg::REG_W-1:0] sampleWord;

  assign firstAxis  = next_axis(touch_readback_pkg::AX_NONE, reqMask);
  assign followAxis = next_axis(axis_ff, reqMask);
  assign sampleWord = {penAtStart_ff, 3'h0, adcData};           // RULE1 RULE2

  always_comb begin
    nxt_state      = state_ff;
    nxt_axis       = axis_ff;
    nxt_adcStart   = 1'b0;
    nxt_penAtStart = penAtStart_ff;
    nxt_setDone    = 1'b0;
    nxt_horiz      = horiz_ff;
    nxt_vert       = vert_ff;
    nxt_press      = press_ff;
    case (state_ff)
      touch_readback_pkg::SEQ_IDLE: begin
        // hold-off only blocks new sets; a set already running completes
        if (measStart && !holdoff_ff && firstAxis != touch_readback_pkg::AX_NONE) begin // RULE3
          nxt_state      = touch_readback_pkg::SEQ_CONV;
          nxt_axis       = firstAxis;
          nxt_adcStart   = 1'b1;
          nxt_penAtStart = penState_ff;                         // RULE2
        end
      end
      touch_readback_pkg::SEQ_CONV: begin
        if (adcDone) begin
          case (axis_ff)
            touch_readback_pkg::AX_HORIZ: nxt_horiz = sampleWord;
            touch_readback_pkg::AX_VERT:  nxt_vert  = sampleWord;
            touch_readback_pkg::AX_PRESS: nxt_press = sampleWord;
            default: ;
          endcase
          if (followAxis == touch_readback_pkg::AX_NONE) begin
            nxt_state   = touch_readback_pkg::SEQ_IDLE;
            nxt_axis    = touch_readback_pkg::AX_NONE;
            nxt_setDone = 1'b1;                                 // RULE8
          end else begin
            nxt_axis       = followAxis;                        // RULE14
            nxt_adcStart   = 1'b1;
            nxt_penAtStart = penState_ff;
          end
        end
      end
      default: begin
        nxt_state = touch_readback_pkg::SEQ_IDLE;
      end
    endcase
    if (srst) begin
      nxt_state      = touch_readback_pkg::SEQ_IDLE;
      nxt_axis       = touch_readback_pkg::AX_NONE;
      nxt_adcStart   = 1'b0;
      nxt_penAtStart = 1'b0;
      nxt_setDone    = 1'b0;
      nxt_horiz      = touch_readback_pkg::RESULT_RST;          // RULE1
      nxt_vert       = touch_readback_pkg::RESULT_RST;
      nxt_press      = touch_readback_pkg::RESULT_RST;
    end
  end

  always_ff @(posedge clk) begin
    state_ff      <= nxt_state;
    axis_ff       <= nxt_axis;
    adcStart_ff   <= nxt_adcStart;
    penAtStart_ff <= nxt_penAtStart;
    setDone_ff    <= nxt_setDone;
    horiz_ff      <= nxt_horiz;
    vert_ff       <= nxt_vert;
    press_ff      <= nxt_press;
  end

  assign adcStart  = adcStart_ff;
  assign matrixSel = axis_ff;
  assign measBusy  = state_ff == touch_readback_pkg::SEQ_CONV;

  // ***************************************************************
  // assertions
  // ***************************************************************
  holdoff_blocks_a: assert property (@(posedge clk) disable iff (srst) // RULE3
    (holdoff_ff && state_ff == touch_readback_pkg::SEQ_IDLE) |=> !adcStart_ff)
    else $error("measurement started during hold-off");

  release_reads_a: assert property (@(posedge clk) disable iff (srst) // RULE4
    holdoff_ff |-> ((readSeen_ff & reqMask) != reqMask))
    else $error("hold-off kept after all enabled results were read");

  other_release_a: assert property (@(posedge clk) disable iff (srst) // RULE5
    (accessEn && !hitResult) |=> !holdoff_ff)
    else $error("hold-off survived access to another register");

  read_starts_a: assert property (@(posedge clk) disable iff (srst) // RULE6
    (accessEn && !pwrite && hitHoriz && reqMask == 3'h7 && readSeen_ff[2:1] != 2'h3)
    |=> (holdoff_ff && readSeen_ff[0]))
    else $error("horizontal read did not start hold-off");

  no_pressure_a: assert property (@(posedge clk) disable iff (srst) // RULE7
    adcStart_ff |-> !(axis_ff == touch_readback_pkg::AX_PRESS && !fourWire))
    else $error("pressure measured in five-wire mode");

  ready_flag_a: assert property (@(posedge clk) disable iff (srst) // RULE8
    setDone_ff |=> status_ff[touch_readback_pkg::BIT_READY])
    else $error("data-ready flag not set after a result set");

  contact_flag_a: assert property (@(posedge clk) disable iff (srst) // RULE9
    contactRise |=> status_ff[touch_readback_pkg::BIT_CONTACT])
    else $error("pen-down flag not set on contact");

  w1c_clear_a: assert property (@(posedge clk) disable iff (srst) // RULE10
    (accessEn && pwrite && hitStatus && pwdata[touch_readback_pkg::BIT_CONTACT] && !contactRise)
    |=> !status_ff[touch_readback_pkg::BIT_CONTACT])
    else $error("pen-down flag not cleared by writing one");

  irq_gate_a: assert property (@(posedge clk) disable iff (srst) // RULE11
    $rose(status_ff[touch_readback_pkg::BIT_READY]) && !mask_ff[touch_readback_pkg::BIT_READY]
    |-> resultReadyIrq)
    else $error("unmasked data-ready flag gave no interrupt");

  mask_reset_a: assert property (@(posedge clk) // RULE12
    srst |=> (mask_ff == touch_readback_pkg::MASK_RST && !contactIrq && !resultReadyIrq))
    else $error("mask bits not one after reset");

  pen_capture_a: assert property (@(posedge clk) disable iff (srst) // RULE2
    (state_ff == touch_readback_pkg::SEQ_CONV && adcDone && axis_ff == touch_readback_pkg::AX_VERT)
    |=> vert_ff[touch_readback_pkg::BIT_CONTACT_FLAG] == $past(penAtStart_ff))
    else $error("contact bit not stored with vertical result");

  one_axis_a: assert property (@(posedge clk) disable iff (srst) // RULE14
    adcStart_ff |=> (!adcStart_ff && measBusy))
    else $error("axis conversions overlapped");

  reset_clear_a: assert property (@(posedge clk) // RULE16
    srst |=> (!holdoff_ff && readSeen_ff == 3'h0 && horiz_ff == touch_readback_pkg::RESULT_RST))
    else $error("reset left hold-off or results set");

  release_c: cover property (@(posedge clk) disable iff (srst) $fell(holdoff_ff));
  set_done_c: cover property (@(posedge clk) disable iff (srst) setDone_ff);
  contact_irq_c: cover property (@(posedge clk) disable iff (srst) $rose(contactIrq));

endmodule : touch_panel_readback_irq

/* File: dv/adc_model.sv */
// Purpose: behavioural adc answering each conversion start of the readback block
// Assumes: one conversion at a time; result depends on the selected axis
// Notes:   slow stretches the answer so both prompt and late replies are seen
`timescale 1ns/100ps
module adc_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        adcStart,
  input  wire logic [1:0]  matrixSel,
  input  wire logic        slow,
  output logic             adcDone,
  output logic [11:0]      adcData
);
  // ***************************************************************
  // conversion timing
  // ***************************************************************
  logic       busy_ff;
  logic [3:0] cnt_ff;
  logic [1:0] sel_ff;
  logic [11:0] value;

  // horiz 0x123, vert 0x223, pressure 0x323
  assign value   = {2'h0, sel_ff + 2'h1, 8'h23};
  // data only valid with adcDone; inverted otherwise so a stale capture shows
  assign adcData = adcDone ? value : ~value;

  always_ff @(posedge clk) begin
    if (srst) begin
      busy_ff <= 1'b0;
      cnt_ff  <= 4'h0;
      sel_ff  <= 2'h3;
      adcDone <= 1'b0;
    end else begin
      adcDone <= 1'b0;
      if (adcStart) begin
        busy_ff <= 1'b1;
        cnt_ff  <= slow ? 4'h8 : 4'h0;
        sel_ff  <= matrixSel;
      end else if (busy_ff) begin
        if (cnt_ff == 4'h0) begin
          adcDone <= 1'b1;
          busy_ff <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff - 4'h1;
        end
      end
    end
  end
endmodule : adc_model

/* File: dv/touch_panel_readback_irq_tb.sv */
// Purpose: self-checking bench for result readback, hold-off and touch interrupts
// Assumes: apb master with one idle cycle between transfers
// Notes:   expected results follow the adc model's fixed per-axis values
`timescale 1ns/100ps
module touch_panel_readback_irq_tb;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, errv;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        penComparator, measStart, adcStart, adcDone, slow;
  logic [1:0]  matrixSel;
  logic [5:0]  selLog;
  logic [11:0] adcData;
  logic        measHoldoff, measBusy, resultReadyIrq, contactIrq, irq;
  int          num_errors, compares, starts;

  touch_panel_readback_irq touch_panel_readback_irq_i (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .penComparator(penComparator), .measStart(measStart),
    .adcStart(adcStart), .matrixSel(matrixSel), .adcDone(adcDone),
    .adcData(adcData), .measHoldoff(measHoldoff), .measBusy(measBusy),
    .resultReadyIrq(resultReadyIrq), .contactIrq(contactIrq), .irq(irq));

  adc_model adc_model_i (
    .clk(clk), .srst(srst), .adcStart(adcStart), .matrixSel(matrixSel),
    .slow(slow), .adcDone(adcDone), .adcData(adcData));

  always #2 clk = ~clk;

  // conversion starts are counted to see which axes really ran
  always @(posedge clk) begin
    if (adcStart === 1'b1) begin
      starts++;
      selLog <= {selLog[3:0], matrixSel};
    end
  end

  // ***************************************************************
  // tasks
  // ***************************************************************
  task stop_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'h0};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task rdchk(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk("prdata", rdv, exp);
  endtask : rdchk

  // request a set; a refused request simply never raises measBusy
  task meas();
    int n;
    @(posedge clk);
    measStart <= 1'b1;
    @(posedge clk);
    measStart <= 1'b0;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (measBusy === 1'b0) break;
    end
    if (n == 200) begin
      num_errors++;
      stop_test();
    end
    repeat (3) @(posedge clk);
    #1;
  endtask : meas

  task pen(input logic lvl);
    @(posedge clk);
    penComparator <= lvl;
    repeat (8) @(posedge clk);
    #1;
  endtask : pen

  // ***************************************************************
  // sequence
  // ***************************************************************
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0;
    pwdata = 32'h0;
    penComparator = 1'b0;
    measStart = 1'b0;
    slow = 1'b0;
    selLog = 6'h0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rdchk(touch_readback_pkg::IDX_STATUS, 32'h0);
    rdchk(touch_readback_pkg::IDX_MASK, 32'h0600);
    rdchk(touch_readback_pkg::IDX_HORIZ, 32'h0);
    rdchk(touch_readback_pkg::IDX_VERT, 32'h0);
    rdchk(touch_readback_pkg::IDX_PRESS, 32'h0);
    apb(1'b0, 16'h4000, 32'h0);
    chk("pslverr", errv, 32'h1);
    apb(1'b1, touch_readback_pkg::IDX_CTRL, 32'h0701);
    apb(1'b1, touch_readback_pkg::IDX_MASK, 32'h0);
    pen(1'b1);
    chk("contactIrq", contactIrq, 32'h1);
    apb(1'b1, touch_readback_pkg::IDX_STATUS, 32'h0);
    chk("contactIrq", contactIrq, 32'h1);
    apb(1'b1, touch_readback_pkg::IDX_STATUS, 32'h0200);
    chk("contactIrq", contactIrq, 32'h0);
    meas();
    chk("starts", starts, 32'h3);
    chk("matrixSel", selLog, 32'h6);
    chk("resultReadyIrq", resultReadyIrq, 32'h1);
    chk("irq", irq, 32'h1);
    rdchk(touch_readback_pkg::IDX_HORIZ, 32'h8123);
    chk("measHoldoff", measHoldoff, 32'h1);
    meas();
    chk("starts", starts, 32'h3);
    rdchk(touch_readback_pkg::IDX_VERT, 32'h8223);
    chk("measHoldoff", measHoldoff, 32'h1);
    rdchk(touch_readback_pkg::IDX_PRESS, 32'h8323);
    chk("measHoldoff", measHoldoff, 32'h0);
    rdchk(touch_readback_pkg::IDX_HORIZ, 32'h8123);
    chk("measHoldoff", measHoldoff, 32'h1);
    rdchk(touch_readback_pkg::IDX_STATUS, 32'h0400);
    chk("measHoldoff", measHoldoff, 32'h0);
    apb(1'b1, touch_readback_pkg::IDX_STATUS, 32'h0400);
    chk("resultReadyIrq", resultReadyIrq, 32'h0);
    // five-wire with pressure still enabled: only horizontal may run
    apb(1'b1, touch_readback_pkg::IDX_MASK, 32'h0400);
    apb(1'b1, touch_readback_pkg::IDX_CTRL, 32'h0500);
    slow <= 1'b1;
    pen(1'b0);
    meas();
    chk("starts", starts, 32'h4);
    chk("matrixSel", selLog, 32'h18);
    chk("resultReadyIrq", resultReadyIrq, 32'h0);
    rdchk(touch_readback_pkg::IDX_HORIZ, 32'h0123);
    chk("measHoldoff", measHoldoff, 32'h0);
    rdchk(touch_readback_pkg::IDX_PRESS, 32'h8323);
    rdchk(touch_readback_pkg::IDX_STATUS, 32'h0400);
    pen(1'b1);
    chk("contactIrq", contactIrq, 32'h1);
    apb(1'b1, touch_readback_pkg::IDX_CTRL, 32'h0701);
    rdchk(touch_readback_pkg::IDX_HORIZ, 32'h0123);
    chk("measHoldoff", measHoldoff, 32'h1);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    chk("measHoldoff", measHoldoff, 32'h0);
    rdchk(touch_readback_pkg::IDX_MASK, 32'h0600);
    stop_test();
  end
endmodule : touch_panel_readback_irq_tb
